// [verilog/odc_pkg.sv]
// Constants and types shared by the octal converter command port
package odc_pkg;
  localparam int          N_CH          = 8;
  localparam int          CODE_W        = 16;
  // Address map
  localparam logic [6:0]  GLOBAL_ADDR   = 7'h73;
  localparam logic [1:0]  PIN_LOW       = 2'h0;
  localparam logic [1:0]  PIN_FLOAT     = 2'h1;
  localparam logic [1:0]  PIN_HIGH      = 2'h2;
  // Commands and channel select
  localparam logic [3:0]  CMD_WRITE     = 4'h0;
  localparam logic [3:0]  CMD_UPDATE    = 4'h1;
  localparam logic [3:0]  CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD    = 4'h3;
  localparam logic [3:0]  CMD_PWR_DOWN  = 4'h4;
  localparam logic [3:0]  CH_ALL        = 4'hf;
  // Values after reset
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [7:0]  OUT_EN_RESET  = 8'hff;
  // Serial framing
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [2:0]  BYTE_ADDR     = 3'h0;
  localparam logic [2:0]  BYTE_CMD      = 3'h1;
  localparam logic [2:0]  BYTE_DATA_HI  = 3'h2;
  localparam logic [2:0]  BYTE_LAST     = 3'h3;
  localparam logic [2:0]  BYTE_EXTRA    = 3'h4;
  // Power-up delays
  localparam int          CLK_MHZ       = 250;
  localparam int          WAKE_US       = 5;
  localparam int          BIAS_5V_US    = 12;
  localparam int          BIAS_3V_US    = 30;
  localparam int          WAKE_CYCLES   = WAKE_US * CLK_MHZ;
  localparam int          BIAS_5V_CYCLES = BIAS_5V_US * CLK_MHZ;
  localparam int          BIAS_3V_CYCLES = BIAS_3V_US * CLK_MHZ;
  localparam int          TIMER_W       = 13;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  ch;
    logic [15:0] data;
  } odc_word_t;

  typedef enum logic [1:0] {
    ODC_BUS_IDLE,
    ODC_BUS_ARMED,
    ODC_BUS_ACTIVE
  } odc_bus_t;
endpackage

// [verilog/odc_i2c_link.sv]
// Serial receiver of the command port, clocked by the bus clock
`timescale 1ns/1ps
module odc_i2c_link (
  // Link clock and frame reset
  input  wire logic          scl,
  input  wire logic          link_rst,
  // Serial data line
  input  wire logic          sda_i,
  output logic               sda_oe_n,
  // Own address, static while frames run
  input  wire logic [6:0]    dev_addr,
  // Assembled word and its per-frame ready flag
  output odc_pkg::odc_word_t word,
  output logic               word_tgl
);
  logic [3:0]         bit_cnt;
  logic [3:0]         next_bit_cnt;
  logic [2:0]         byte_idx;
  logic [2:0]         next_byte_idx;
  logic [7:0]         shreg;
  logic [7:0]         next_shreg;
  logic [15:0]        acc;
  logic [15:0]        next_acc;
  logic               addressed;
  logic               next_addressed;
  odc_pkg::odc_word_t next_word;
  logic               next_word_tgl;
  logic               next_sda_oe_n;
  logic               ack_ok;
  logic               addr_hit;

  always_comb
  begin
    addr_hit = (shreg[7:1] == dev_addr) ||
               (shreg[7:1] == odc_pkg::GLOBAL_ADDR);
    if (byte_idx == odc_pkg::BYTE_ADDR)
      ack_ok = addr_hit && !shreg[0]; // R2 R18
    else
      ack_ok = addressed && (byte_idx <= odc_pkg::BYTE_LAST); // R3 R5
  end

  always_comb
  begin
    next_bit_cnt   = bit_cnt;
    next_byte_idx  = byte_idx;
    next_shreg     = shreg;
    next_acc       = acc;
    next_addressed = addressed;
    next_word      = word;
    next_word_tgl  = word_tgl;
    if (bit_cnt != odc_pkg::BIT_ACK)
    begin
      next_shreg   = {shreg[6:0], sda_i};
      next_bit_cnt = bit_cnt + 4'h1;
    end
    else
    begin
      next_bit_cnt = 4'h0;
      if (byte_idx != odc_pkg::BYTE_EXTRA)
        next_byte_idx = byte_idx + 3'h1;
      if (byte_idx == odc_pkg::BYTE_ADDR)
        next_addressed = ack_ok;
      if (byte_idx == odc_pkg::BYTE_CMD)
        next_acc[15:8] = shreg; // R6
      if (byte_idx == odc_pkg::BYTE_DATA_HI)
        next_acc[7:0] = shreg; // R7
      // Word handed over only once the third byte is complete
      if (byte_idx == odc_pkg::BYTE_LAST && addressed)
      begin
        next_word     = {acc, shreg}; // R4
        next_word_tgl = 1'b1;
      end
    end
  end

  always_ff @(posedge scl or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt   <= 4'h0;
      byte_idx  <= 3'h0;
      shreg     <= 8'h00;
      acc       <= 16'h0000;
      addressed <= 1'b0;
      word_tgl  <= 1'b0;
    end
    else
    begin
      bit_cnt   <= next_bit_cnt;
      byte_idx  <= next_byte_idx;
      shreg     <= next_shreg;
      acc       <= next_acc;
      addressed <= next_addressed;
      word_tgl  <= next_word_tgl;
    end
  end

  // Word survives frame resets; the flag drops at every frame end, so a
  // known level crosses and each frame hands over at most once
  always_ff @(posedge scl)
  begin
    word <= next_word;
  end

  // Driven on the falling edge so the line is steady while the clock is high
  always_comb
  begin
    next_sda_oe_n = 1'b1;
    if (bit_cnt == odc_pkg::BIT_ACK)
      next_sda_oe_n = !ack_ok; // R2 R3 R5 R18
  end

  always_ff @(negedge scl or posedge link_rst)
  begin
    if (link_rst)
      sda_oe_n <= 1'b1;
    else
      sda_oe_n <= next_sda_oe_n;
  end

  AST_ACK_GLOBAL: assert property (@(posedge scl) disable iff (link_rst)
    (bit_cnt == odc_pkg::BIT_ACK && byte_idx == odc_pkg::BYTE_ADDR &&
     shreg == {odc_pkg::GLOBAL_ADDR, 1'b0}) |-> !sda_oe_n) // R2
    else $error("global address write not acknowledged");

  AST_NO_READ_ACK: assert property (@(posedge scl) disable iff (link_rst)
    (bit_cnt == odc_pkg::BIT_ACK && byte_idx == odc_pkg::BYTE_ADDR &&
     shreg[0]) |-> sda_oe_n) // R18
    else $error("read direction acknowledged");

  AST_ACK_DATA: assert property (@(posedge scl) disable iff (link_rst)
    (bit_cnt == odc_pkg::BIT_ACK && addressed &&
     byte_idx >= odc_pkg::BYTE_CMD && byte_idx <= odc_pkg::BYTE_LAST)
    |-> !sda_oe_n) // R3
    else $error("data byte not acknowledged");

  AST_NO_EXTRA_ACK: assert property (@(posedge scl) disable iff (link_rst)
    (byte_idx == odc_pkg::BYTE_EXTRA) |-> sda_oe_n) // R5
    else $error("extra byte acknowledged");
endmodule // odc_i2c_link

// [verilog/odc_cmd_port.sv]
// Top of the octal converter command port: bus framing and command logic
`timescale 1ns/1ps
// Behaviour
// R1: Master sends START, address, write bit.
// R2: Acknowledge address matching pins or global.
// R3: Acknowledge each of three data bytes.
// R4: Execute only after all three bytes.
// R5: Never acknowledge bytes beyond the third.
// R6: First byte holds command and channel nibbles.
// R7: Next two bytes: code, MSB first.
// R8: Write loads selected input register only.
// R9: Update copies input register into DAC register.
// R10: Update powers the channel back up.
// R11: Address from three-level pins; global 1110011.
// R12: Command 0100 powers down selected channels.
// R13: Power-down keeps all register contents.
// R14: Powered-down channel output driver disabled.
// R15: Bias off only when all channels down.
// R16: Waking with others active waits 5 us.
// R17: Waking from all-down waits 12/30 us.
// R18: Read direction is never acknowledged.
// R19: Commands 0-3 write/update; channel 1111 all.
// R20: Undefined codes change nothing.
module odc_cmd_port #(
  parameter int BIAS_3V_CYCLES = odc_pkg::BIAS_3V_CYCLES
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Two-wire bus
  input  wire logic              scl,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  // Address straps, three-level each
  input  wire logic [1:0]        addr_select_pin_low,
  input  wire logic [1:0]        addr_select_pin_mid,
  input  wire logic [1:0]        addr_select_pin_high,
  // Supply indication, same clock domain
  input  wire logic              supply_low_v,
  // Converter controls
  output logic [7:0][15:0]       dac_code,
  output logic [7:0]             out_enable,
  output logic                   bias_enable,
  output logic                   powerup_wait
);
  logic [2:0]                    scl_sync;
  logic [2:0]                    sda_sync;
  logic [2:0]                    tgl_sync;
  logic [2:0]                    next_scl_sync;
  logic [2:0]                    next_sda_sync;
  logic [2:0]                    next_tgl_sync;
  logic                          scl_f;
  logic                          sda_f;
  logic                          next_scl_f;
  logic                          next_sda_f;
  logic                          tgl_seen;
  logic                          next_tgl_seen;
  logic                          word_go;
  odc_pkg::odc_bus_t             bus_state;
  odc_pkg::odc_bus_t             next_bus_state;
  logic                          link_rst;
  logic                          next_link_rst;
  logic                          bus_start;
  logic                          bus_stop;
  logic [6:0]                    slave_addr_bits;
  logic [6:0]                    next_slave_addr_bits;
  odc_pkg::odc_word_t            link_word;
  logic                          link_tgl;
  logic [7:0][15:0]              in_reg;
  logic [7:0][15:0]              next_in_reg;
  logic [7:0][15:0]              next_dac_code;
  logic [7:0]                    next_out_enable;
  logic                          next_bias_enable;
  logic                          next_powerup_wait;
  logic [odc_pkg::TIMER_W-1:0]   wait_cnt;
  logic [odc_pkg::TIMER_W-1:0]   next_wait_cnt;
  logic [7:0]                    sel_mask;
  logic [7:0]                    upd_mask;
  logic                          do_write;

  function automatic logic [1:0] pin_digit(input logic [1:0] pin);
    if (pin == odc_pkg::PIN_LOW)
      pin_digit = 2'h0;
    else if (pin == odc_pkg::PIN_HIGH)
      pin_digit = 2'h2;
    else
      pin_digit = 2'h1;
  endfunction

  // Base-3 strap index into address: bits 6..4 = i/4+1, 1..0 = i mod 4
  function automatic logic [6:0] strap_addr(input logic [4:0] idx);
    logic [2:0] hi;
    hi = 3'(idx[4:2] + 3'h1);
    strap_addr = {hi, 2'b00, idx[1:0]}; // R11
  endfunction

  function automatic logic [7:0] chan_mask(input logic [3:0] ch);
    if (ch == odc_pkg::CH_ALL)
      chan_mask = 8'hff; // R19
    else if (ch < 4'h8)
      chan_mask = 8'(8'h01 << ch[2:0]);
    else
      chan_mask = 8'h00; // R20
  endfunction

  // Synchronisers; the first stage feeds only the second
  always_comb
  begin
    next_scl_sync = {scl_sync[1:0], scl};
    next_sda_sync = {sda_sync[1:0], sda_i};
    next_tgl_sync = {tgl_sync[1:0], link_tgl};
    next_scl_f    = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    next_sda_f    = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
    word_go       = (tgl_sync[1] == tgl_sync[2]) && tgl_sync[2] && !tgl_seen;
    next_tgl_seen = (tgl_sync[1] == tgl_sync[2]) ? tgl_sync[2] : tgl_seen;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      tgl_sync <= 3'h0;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      tgl_seen <= 1'b0;
    end
    else
    begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      tgl_sync <= next_tgl_sync;
      scl_f    <= next_scl_f;
      sda_f    <= next_sda_f;
      tgl_seen <= next_tgl_seen;
    end
  end

  // Frame control: the link logic is held reset outside frames, since
  // its clock may stop and a START must restart the bit count
  always_comb
  begin
    bus_start      = scl_f && sda_f && !next_sda_f && next_scl_f; // R1
    bus_stop       = scl_f && !sda_f && next_sda_f && next_scl_f;
    next_bus_state = bus_state;
    next_link_rst  = link_rst;
    case (bus_state)
      odc_pkg::ODC_BUS_IDLE:
        if (bus_start)
          next_bus_state = odc_pkg::ODC_BUS_ARMED;
      odc_pkg::ODC_BUS_ARMED:
        if (!next_scl_f)
        begin
          next_bus_state = odc_pkg::ODC_BUS_ACTIVE;
          next_link_rst  = 1'b0;
        end
      default:
        if (bus_start || bus_stop)
        begin
          next_bus_state = bus_start ? odc_pkg::ODC_BUS_ARMED
                                     : odc_pkg::ODC_BUS_IDLE;
          next_link_rst  = 1'b1;
        end
    endcase
  end

  // Straps are caught while reset is held; they must not move afterwards
  always_comb
  begin
    next_slave_addr_bits = slave_addr_bits;
    if (sys_rst)
      next_slave_addr_bits = strap_addr(5'(
        pin_digit(addr_select_pin_high) * 9 +
        pin_digit(addr_select_pin_mid) * 3 +
        pin_digit(addr_select_pin_low))); // R11
  end

  always_ff @(posedge clk)
  begin
    slave_addr_bits <= next_slave_addr_bits;
    if (sys_rst)
    begin
      bus_state <= odc_pkg::ODC_BUS_IDLE;
      link_rst  <= 1'b1;
      sda_o     <= 1'b0;
    end
    else
    begin
      bus_state <= next_bus_state;
      link_rst  <= next_link_rst;
      sda_o     <= 1'b0;
    end
  end

  odc_i2c_link u_link (
    .scl      (scl),
    .link_rst (link_rst),
    .sda_i    (sda_i),
    .sda_oe_n (sda_oe_n),
    .dev_addr (slave_addr_bits),
    .word     (link_word),
    .word_tgl (link_tgl)
  );

  // Command execution, one word per rising ready flag from the link
  always_comb
  begin
    next_in_reg     = in_reg;
    next_dac_code   = dac_code;
    next_out_enable = out_enable;
    next_wait_cnt   = (wait_cnt != '0) ? wait_cnt - 1'b1 : wait_cnt;
    sel_mask        = chan_mask(link_word.ch);
    upd_mask        = 8'h00;
    do_write        = 1'b0;
    if (word_go && sel_mask != 8'h00) // R4 R20
    begin
      case (link_word.cmd)
        odc_pkg::CMD_WRITE:
          do_write = 1'b1; // R19
        odc_pkg::CMD_UPDATE:
          upd_mask = sel_mask; // R19
        odc_pkg::CMD_WR_UPD_ALL:
        begin
          do_write = 1'b1;
          upd_mask = 8'hff; // R19
        end
        odc_pkg::CMD_WR_UPD:
        begin
          do_write = 1'b1;
          upd_mask = sel_mask; // R19
        end
        odc_pkg::CMD_PWR_DOWN:
          next_out_enable = out_enable & ~sel_mask; // R12 R13 R14
        default:
          upd_mask = 8'h00; // R20
      endcase
    end
    for (int i = 0; i < odc_pkg::N_CH; i++)
    begin
      if (do_write && sel_mask[i])
        next_in_reg[i] = link_word.data; // R7 R8
      if (upd_mask[i])
      begin
        next_dac_code[i]   = next_in_reg[i]; // R9
        next_out_enable[i] = 1'b1; // R10
      end
    end
    // Delay only when a sleeping channel is woken
    if ((upd_mask & ~out_enable) != 8'h00)
    begin
      if (out_enable != 8'h00)
        next_wait_cnt = odc_pkg::TIMER_W'(odc_pkg::WAKE_CYCLES); // R16
      else if (supply_low_v)
        next_wait_cnt = odc_pkg::TIMER_W'(BIAS_3V_CYCLES); // R17
      else
        next_wait_cnt = odc_pkg::TIMER_W'(odc_pkg::BIAS_5V_CYCLES); // R17
    end
    next_bias_enable  = next_out_enable != 8'h00; // R15
    next_powerup_wait = next_wait_cnt != '0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      in_reg       <= {odc_pkg::N_CH{odc_pkg::CODE_RESET}};
      dac_code     <= {odc_pkg::N_CH{odc_pkg::CODE_RESET}};
      out_enable   <= odc_pkg::OUT_EN_RESET;
      bias_enable  <= 1'b1;
      wait_cnt     <= '0;
      powerup_wait <= 1'b0;
    end
    else
    begin
      in_reg       <= next_in_reg;
      dac_code     <= next_dac_code;
      out_enable   <= next_out_enable;
      bias_enable  <= next_bias_enable;
      wait_cnt     <= next_wait_cnt;
      powerup_wait <= next_powerup_wait;
    end
  end

  AST_WRITE_NO_UPDATE: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd == odc_pkg::CMD_WRITE) |=>
    $stable(dac_code) && $stable(out_enable)) // R8
    else $error("write command touched DAC registers");

  AST_UPDATE_COPIES: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd == odc_pkg::CMD_UPDATE &&
     link_word.ch == 4'h0) |=> dac_code[0] == $past(in_reg[0])) // R9
    else $error("update did not copy input register");

  AST_UPDATE_WAKES: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd == odc_pkg::CMD_WR_UPD && sel_mask != 8'h00)
    |=> (out_enable & $past(sel_mask)) == $past(sel_mask)) // R10
    else $error("updated channel still powered down");

  AST_PD_KEEPS_REGS: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd == odc_pkg::CMD_PWR_DOWN) |=>
    $stable(dac_code) && $stable(in_reg) &&
    (out_enable & $past(sel_mask)) == 8'h00) // R12 R13 R14
    else $error("power-down disturbed registers or left output on");

  AST_BIAS_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
    bias_enable == (out_enable != 8'h00)) // R15
    else $error("bias enable disagrees with channel states");

  AST_WAKE_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd == odc_pkg::CMD_UPDATE &&
     (sel_mask & ~out_enable) != 8'h00 && out_enable != 8'h00)
    |=> powerup_wait [*8]) // R16
    else $error("power-up delay not started");

  AST_UNDEFINED_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
    (word_go && link_word.cmd > odc_pkg::CMD_PWR_DOWN) |=>
    $stable(in_reg) && $stable(dac_code) && $stable(out_enable)) // R20
    else $error("undefined command changed state");
endmodule // odc_cmd_port

// [tb/odc_i2c_master.sv]
// Behavioural two-wire bus master that writes converter frames
`timescale 1ns/1ps
module odc_i2c_master (
  // Bus clock and data pull-down
  output logic      scl,
  output logic      sda_pull,
  // Resolved data line
  input  wire logic sda
);
  logic link_clk;

  // Bit clock runs free; scl stands high outside frames
  initial
  begin
    link_clk = 1'b0;
    scl      = 1'b1;
    sda_pull = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end

  task automatic tick();
    @(posedge link_clk);
  endtask

  // Data moves a tick after scl falls, so hold time is never cut
  task automatic put_bit(input logic b, output logic seen);
    tick();
    sda_pull = ~b;
    tick();
    scl = 1'b1;
    tick();
    seen = sda;
    tick();
    scl = 1'b0;
  endtask

  // Address byte then n_data bytes taken from the top of data
  task automatic frame(input logic [6:0] addr, input logic rw,
                       input logic [31:0] data, input int n_data,
                       output logic [4:0] acks);
    logic [7:0] b;
    logic       seen;
    acks = 5'h00;
    tick();
    sda_pull = 1'b1;
    tick();
    scl = 1'b0;
    for (int k = 0; k <= n_data; k++)
    begin
      if (k == 0)
        b = {addr, rw};
      else
        b = data[39 - 8 * k -: 8];
      for (int j = 7; j >= 0; j--)
        put_bit(b[j], seen);
      put_bit(1'b1, seen);
      acks[k] = ~seen;
    end
    tick();
    sda_pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b0;
    tick();
  endtask
endmodule // odc_i2c_master

// [tb/test_octal_dac_i2c_command_port.sv]
// Self-checking bench for the octal converter command port
`timescale 1ns/1ps
module test_octal_dac_i2c_command_port;
  localparam int         P3V = 40;
  localparam logic [6:0] A0  = 7'h10;
  logic             clk;
  logic             sys_rst;
  logic             scl;
  logic             sda_pull;
  wire              sda_line;
  logic             sda_o;
  logic             sda_oe_n;
  logic [1:0]       pin_lo;
  logic [1:0]       pin_mid;
  logic [1:0]       pin_hi;
  logic             supply_low_v;
  logic [7:0][15:0] dac_code;
  logic [7:0][15:0] exp_code;
  logic [7:0][15:0] exp_in;
  logic [7:0]       out_enable;
  logic             bias_enable;
  logic             powerup_wait;
  int               n_mismatch;
  int               check_count;
  int               run_len;
  int               last_len;

  odc_cmd_port #(
    .BIAS_3V_CYCLES (P3V)
  ) u_dut (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .scl                  (scl),
    .sda_i                (sda_line),
    .sda_o                (sda_o),
    .sda_oe_n             (sda_oe_n),
    .addr_select_pin_low  (pin_lo),
    .addr_select_pin_mid  (pin_mid),
    .addr_select_pin_high (pin_hi),
    .supply_low_v         (supply_low_v),
    .dac_code             (dac_code),
    .out_enable           (out_enable),
    .bias_enable          (bias_enable),
    .powerup_wait         (powerup_wait)
  );

  odc_i2c_master u_master (
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda      (sda_line)
  );

  // Pull-up: a released line reads high
  assign sda_line = sda_pull ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Length of the last power-up wait pulse, in clk cycles
  always @(posedge clk)
    if (powerup_wait === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len  <= 0;
    end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Straps are only read while reset is held
  task automatic do_reset(input int idx);
    @(negedge clk);
    sys_rst = 1'b1;
    pin_hi  = 2'(idx / 9);
    pin_mid = 2'(idx / 3 % 3);
    pin_lo  = 2'(idx % 3);
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    exp_code = '0;
    exp_in   = '0;
  endtask

  // Expected register effect of one complete accepted frame
  task automatic model(input logic [3:0] c, input logic [3:0] ch,
                       input logic [15:0] d);
    for (int i = 0; i < 8; i++)
      if (ch == odc_pkg::CH_ALL || ch == 4'(i))
      begin
        if (c == odc_pkg::CMD_WRITE || c == odc_pkg::CMD_WR_UPD ||
            c == odc_pkg::CMD_WR_UPD_ALL)
          exp_in[i] = d;
        if (c == odc_pkg::CMD_UPDATE || c == odc_pkg::CMD_WR_UPD)
          exp_code[i] = exp_in[i];
      end
    if (c == odc_pkg::CMD_WR_UPD_ALL && (ch < 4'h8 || ch == 4'hf))
      exp_code = exp_in;
  endtask

  task automatic send(input logic [6:0] a, input logic [3:0] c,
                      input logic [3:0] ch, input logic [15:0] d,
                      input int n, input logic [4:0] ex_ack);
    logic [4:0] acks;
    last_len = 0;
    u_master.frame(a, 1'b0, {c, ch, d, 8'ha5}, n, acks);
    repeat (8) @(negedge clk);
    check("ack", 128'(acks), 128'(ex_ack));
    if (n >= 3 && ex_ack[0])
      model(c, ch, d);
    check("dac_code", dac_code, exp_code);
  endtask

  task automatic wake(input int cyc);
    for (int t = 0; t < 8000 && powerup_wait !== 1'b0; t++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check("wake", 128'(last_len), 128'(cyc));
  endtask

  task automatic t_addr_map();
    logic [4:0] acks;
    logic [6:0] a;
    for (int i = 0; i < 27; i++)
    begin
      do_reset(i);
      a = {3'(i / 4 + 1), 2'h0, 2'(i % 4)};
      u_master.frame(a, 1'b0, 32'h0, 0, acks);
      check("strap ack", 128'(acks), 128'h1);
      u_master.frame(a ^ 7'h04, 1'b0, 32'h0, 0, acks);
      check("foreign ack", 128'(acks), 128'h0);
    end
  endtask

  // Read direction with a full word behind it must do nothing
  task automatic t_read();
    logic [4:0] acks;
    do_reset(0);
    u_master.frame(A0, 1'b1, 32'h30123400, 3, acks);
    repeat (8) @(negedge clk);
    check("read ack", 128'(acks), 128'h0);
    check("dac_code", dac_code, 128'h0);
  endtask

  task automatic t_codes();
    send(A0, odc_pkg::CMD_WRITE, 4'h2, 16'h1234, 4, 5'h0f);
    send(odc_pkg::GLOBAL_ADDR, odc_pkg::CMD_UPDATE, 4'h2, 16'hffff,
         3, 5'h0f);
    send(A0, odc_pkg::CMD_WR_UPD, 4'h5, 16'habcd, 3, 5'h0f);
    send(A0, odc_pkg::CMD_WR_UPD, 4'h1, 16'h7777, 2, 5'h07);
    send(A0, 4'h5, 4'h1, 16'h7777, 3, 5'h0f);
    send(A0, odc_pkg::CMD_WR_UPD, 4'h9, 16'h7777, 3, 5'h0f);
    send(A0, odc_pkg::CMD_WR_UPD_ALL, 4'h0, 16'h5555, 3, 5'h0f);
    send(A0, odc_pkg::CMD_WRITE, odc_pkg::CH_ALL, 16'h0f0f,
         3, 5'h0f);
    send(A0, odc_pkg::CMD_UPDATE, 4'h7, 16'h0000, 3, 5'h0f);
  endtask

  task automatic t_power();
    supply_low_v = 1'b1;
    send(A0, odc_pkg::CMD_PWR_DOWN, odc_pkg::CH_ALL, 16'h1111,
         3, 5'h0f);
    check("out_enable", 128'(out_enable), 128'h0);
    check("bias", 128'(bias_enable), 128'h0);
    send(A0, odc_pkg::CMD_UPDATE, 4'h3, 16'h0000, 3, 5'h0f);
    check("out_enable", 128'(out_enable), 128'h08);
    check("bias", 128'(bias_enable), 128'h1);
    wake(P3V);
    send(A0, odc_pkg::CMD_UPDATE, 4'h0, 16'h0000, 3, 5'h0f);
    check("out_enable", 128'(out_enable), 128'h09);
    wake(odc_pkg::WAKE_CYCLES);
    supply_low_v = 1'b0;
    send(A0, odc_pkg::CMD_PWR_DOWN, odc_pkg::CH_ALL, 16'h0000,
         3, 5'h0f);
    send(A0, odc_pkg::CMD_WR_UPD_ALL, 4'h6, 16'h2222, 3, 5'h0f);
    check("out_enable", 128'(out_enable), 128'hff);
    wake(odc_pkg::BIAS_5V_CYCLES);
  endtask

  initial
  begin
    n_mismatch   = 0;
    check_count  = 0;
    run_len      = 0;
    last_len     = 0;
    sys_rst      = 1'b1;
    supply_low_v = 1'b0;
    pin_lo       = 2'h0;
    pin_mid      = 2'h0;
    pin_hi       = 2'h0;
    exp_code     = '0;
    exp_in       = '0;
    t_addr_map();
    t_read();
    t_codes();
    t_power();
    end_of_test();
  end

  // Whole run is near 160 us; a hang is cut well after that
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule // test_octal_dac_i2c_command_port
